// *** hdl/i2cst_slave.sv ***
// two-wire bus slave engine with address match and bus time-out
`timescale 1ns/1ps
module i2cst_slave (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic slow_clk_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic module_enable_i,
    input wire logic [2:0] interface_mode_sel_i,
    input wire logic [1:0] glitch_filter_sel_i,
    input wire logic [6:0] own_address_i,
    input wire logic transmit_select_i,
    input wire logic ack_to_send_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_data_wr_i,
    input wire logic data_rd_i,
    input wire logic timeout_ctrl_wr_i,
    input wire logic timeout_enable_i,
    input wire logic [5:0] timeout_period_sel_i,
    input wire logic timeout_flag_clr_i,
    output logic [7:0] shift_data_o,
    output logic byte_done_flag_o,
    output logic address_match_flag_o,
    output logic bus_busy_flag_o,
    output logic master_read_flag_o,
    output logic ack_received_o,
    output logic timeout_enable_o,
    output logic timeout_flag_o,
    output logic irq_o
);
    // filtered lines: bit 0 clock, bit 1 data
    logic [1:0] line_raw;
    logic [1:0] line_f;
    logic scl_f;
    logic sda_f;
    logic scl_p_q;
    logic sda_p_q;
    // bus events
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic eng_ok;
    logic step_ok;
    logic addr_hit;
    logic shift_in;
    logic shift_out;
    // protocol engine state
    i2cst_pkg::i2cst_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shreg_q;
    logic sda_drv_q;
    logic hold_q;
    logic tx_mode_q;
    logic addr_phase_q;
    logic irq_byte_q;
    // status flags
    logic byte_done_q;
    logic addr_match_q;
    logic mread_q;
    logic ack_rx_q;
    logic busy_q;
    // time-out control and crossing
    logic to_en_q;
    logic to_flag_q;
    logic to_irq_q;
    logic counting_q;
    logic run_q;
    logic clr_tgl_q;
    logic ovf_tgl;
    logic ovf_s1_q;
    logic ovf_s2_q;
    logic ovf_s3_q;
    logic tmo_evt;

    // true once the sample history is steady for the chosen filter
    function automatic logic i2cst_stable(input logic [3:0] h,
                                          input logic [1:0] sel);
        logic r;
        r = 1'b1;
        if (sel == i2cst_pkg::FLT_TWO) begin
            r = (h[1] == h[0]);
        end else if (sel != i2cst_pkg::FLT_NONE) begin
            r = (h == 4'h0) || (h == 4'hf);
        end
        return r;
    endfunction : i2cst_stable

    assign line_raw = {sda_i, scl_i};

    // per line: two-stage sync, then glitch filter
    for (genvar gi = 0; gi < 2; gi++) begin : g_line
        logic s1_q;
        logic s2_q;
        logic [3:0] hist_q;
        logic flt_q;
        always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
                s1_q <= i2cst_pkg::LINE_IDLE;
                s2_q <= i2cst_pkg::LINE_IDLE;
                hist_q <= 4'hf;
                flt_q <= i2cst_pkg::LINE_IDLE;
            end else begin
                s1_q <= line_raw[gi];
                s2_q <= s1_q;
                hist_q <= {hist_q[2:0], s2_q};
                if (i2cst_stable(hist_q, glitch_filter_sel_i)) begin
                    flt_q <= hist_q[0];
                end
            end
        end
        assign line_f[gi] = flt_q;
    end

    assign scl_f = line_f[0];
    assign sda_f = line_f[1];

    // previous filtered levels for edge detection
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            scl_p_q <= i2cst_pkg::LINE_IDLE;
            sda_p_q <= i2cst_pkg::LINE_IDLE;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // edge and condition decode
    assign scl_rise = scl_f && !scl_p_q;
    assign scl_fall = !scl_f && scl_p_q;
    assign start_ev = scl_f && scl_p_q && sda_p_q && !sda_f;
    assign stop_ev = scl_f && scl_p_q && !sda_p_q && sda_f;
    assign eng_ok = module_enable_i &&
                    (interface_mode_sel_i == i2cst_pkg::MODE_I2C_SLAVE);
    assign step_ok = eng_ok && !tmo_evt && !start_ev && !stop_ev;
    // eighth rise of the address byte with equal address
    assign addr_hit = step_ok && (state_q == i2cst_pkg::ST_ADDR) &&
                      scl_rise && (bit_cnt_q == i2cst_pkg::ADDR_LAST_BIT) &&
                      (shreg_q[6:0] == own_address_i);
    // receive sampling on rising edges, MSB first
    assign shift_in = step_ok && scl_rise &&
                      (bit_cnt_q < i2cst_pkg::BYTE_BITS) &&
                      ((state_q == i2cst_pkg::ST_ADDR) ||
                       ((state_q == i2cst_pkg::ST_DATA) && !tx_mode_q));
    assign shift_out = step_ok && scl_fall && tx_mode_q &&
                       (state_q == i2cst_pkg::ST_DATA) &&
                       (bit_cnt_q < i2cst_pkg::BYTE_BITS);

    // shared data register; kept across time-out
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            shreg_q <= 8'h00;
        end else if (tx_data_wr_i) begin
            shreg_q <= tx_data_i;
        end else if (shift_in) begin
            shreg_q <= {shreg_q[6:0], sda_f};
        end else if (shift_out) begin
            shreg_q <= {shreg_q[6:0], 1'b0};
        end
    end

    // protocol engine, line drive and byte status
    always_ff @(posedge sys_clk_i) begin
        irq_byte_q <= 1'b0;
        if (sys_rst_i || !eng_ok || tmo_evt) begin
            // engine and status back to reset values
            state_q <= i2cst_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            sda_drv_q <= 1'b0;
            hold_q <= 1'b0;
            tx_mode_q <= 1'b0;
            addr_phase_q <= 1'b0;
            byte_done_q <= i2cst_pkg::BYTE_DONE_RST;
            addr_match_q <= 1'b0;
            mread_q <= 1'b0;
            ack_rx_q <= i2cst_pkg::ACK_RX_RST;
        end else if (start_ev) begin
            // (repeated) start: collect an address
            state_q <= i2cst_pkg::ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_drv_q <= 1'b0;
            hold_q <= 1'b0;
            addr_phase_q <= 1'b1;
            addr_match_q <= 1'b0;
            byte_done_q <= 1'b0;
        end else if (stop_ev) begin
            state_q <= i2cst_pkg::ST_IDLE;
            sda_drv_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            case (state_q)
                i2cst_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (addr_hit) begin
                            addr_match_q <= 1'b1;
                            mread_q <= sda_f;
                            byte_done_q <= 1'b1;
                            irq_byte_q <= 1'b1;
                        end else if (bit_cnt_q ==
                                     i2cst_pkg::ADDR_LAST_BIT) begin
                            state_q <= i2cst_pkg::ST_WAIT;
                        end
                    end else if (scl_fall &&
                                 bit_cnt_q == i2cst_pkg::BYTE_BITS) begin
                        state_q <= i2cst_pkg::ST_ACK;
                        sda_drv_q <= 1'b1;
                    end
                end
                i2cst_pkg::ST_ACK: begin
                    // ninth clock over: release data, hold clock
                    if (scl_fall) begin
                        sda_drv_q <= 1'b0;
                        hold_q <= 1'b1;
                        state_q <= i2cst_pkg::ST_HOLD;
                    end
                end
                i2cst_pkg::ST_HOLD: begin
                    // data write or dummy read frees the clock
                    if (tx_data_wr_i || data_rd_i) begin
                        hold_q <= 1'b0;
                        byte_done_q <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        addr_phase_q <= 1'b0;
                        tx_mode_q <= transmit_select_i;
                        sda_drv_q <= transmit_select_i &&
                            !(tx_data_wr_i ? tx_data_i[7] : shreg_q[7]);
                        state_q <= i2cst_pkg::ST_DATA;
                    end
                end
                i2cst_pkg::ST_DATA: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (!tx_mode_q &&
                            bit_cnt_q == i2cst_pkg::ADDR_LAST_BIT) begin
                            byte_done_q <= 1'b1;
                            irq_byte_q <= 1'b1;
                        end
                    end else if (scl_fall) begin
                        if (bit_cnt_q == i2cst_pkg::BYTE_BITS) begin
                            if (tx_mode_q) begin
                                sda_drv_q <= 1'b0;
                                state_q <= i2cst_pkg::ST_MACK;
                            end else begin
                                sda_drv_q <= !ack_to_send_i;
                                state_q <= i2cst_pkg::ST_ACK;
                            end
                        end else if (tx_mode_q) begin
                            sda_drv_q <= !shreg_q[6];
                        end
                    end
                end
                i2cst_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        ack_rx_q <= sda_f;
                        byte_done_q <= 1'b1;
                        irq_byte_q <= 1'b1;
                    end else if (scl_fall) begin
                        if (!ack_rx_q) begin
                            hold_q <= 1'b1;
                            state_q <= i2cst_pkg::ST_HOLD;
                        end else begin
                            state_q <= i2cst_pkg::ST_WAIT;
                        end
                    end
                end
                default: begin
                    // idle or waiting for stop: lines released
                    sda_drv_q <= 1'b0;
                    hold_q <= 1'b0;
                end
            endcase
        end
    end

    // bus busy between start and stop
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !eng_ok || tmo_evt) begin
            busy_q <= 1'b0;
        end else if (start_ev) begin
            busy_q <= 1'b1;
        end else if (stop_ev) begin
            busy_q <= 1'b0;
        end
    end

    // time-out enable and flag; the time-out beats a software write or clear
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            to_en_q <= 1'b0;
            to_flag_q <= 1'b0;
            to_irq_q <= 1'b0;
        end else begin
            to_irq_q <= tmo_evt;
            if (tmo_evt) begin
                to_en_q <= 1'b0;
            end else if (timeout_ctrl_wr_i) begin
                to_en_q <= timeout_enable_i;
            end
            if (tmo_evt) begin
                to_flag_q <= 1'b1;
            end else if (timeout_flag_clr_i) begin
                to_flag_q <= 1'b0;
            end
        end
    end

    // count window from address match to the next start, stop or time-out
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            counting_q <= 1'b0;
            run_q <= 1'b0;
            clr_tgl_q <= 1'b0;
        end else begin
            run_q <= counting_q && to_en_q;
            if (scl_fall) begin
                clr_tgl_q <= ~clr_tgl_q;
            end
            if (!eng_ok || tmo_evt || stop_ev || start_ev) begin
                counting_q <= 1'b0;
            end else if (addr_hit) begin
                counting_q <= 1'b1;
            end
        end
    end

    // overflow toggle back from the slow domain
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ovf_s1_q <= 1'b0;
            ovf_s2_q <= 1'b0;
            ovf_s3_q <= 1'b0;
        end else begin
            ovf_s1_q <= ovf_tgl;
            ovf_s2_q <= ovf_s1_q;
            ovf_s3_q <= ovf_s2_q;
        end
    end
    assign tmo_evt = ovf_s2_q ^ ovf_s3_q;

    // slow clock time-out counter
    i2cst_tmo u_tmo (
        .slow_clk_i(slow_clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(run_q),
        .clr_tgl_i(clr_tgl_q),
        .period_sel_i(timeout_period_sel_i),
        .ovf_tgl_o(ovf_tgl)
    );

    // open-drain lines only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = hold_q;
    assign sda_oe_o = sda_drv_q;
    assign shift_data_o = shreg_q;
    assign byte_done_flag_o = byte_done_q;
    assign address_match_flag_o = addr_match_q;
    assign bus_busy_flag_o = busy_q;
    assign master_read_flag_o = mread_q;
    assign ack_received_o = ack_rx_q;
    assign timeout_enable_o = to_en_q;
    assign timeout_flag_o = to_flag_q;
    assign irq_o = irq_byte_q || to_irq_q;

    // checks on the system clock
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_start_busy;
        eng_ok && start_ev && !tmo_evt |=> bus_busy_flag_o;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start did not set bus busy");

    property p_stop_free;
        stop_ev |=> !bus_busy_flag_o && !sda_oe_o && !scl_oe_o;
    endproperty
    a_stop_free: assert property (p_stop_free)
        else $error("stop did not free the bus");

    property p_match;
        addr_hit |=> address_match_flag_o && irq_o &&
                    (master_read_flag_o == $past(sda_f));
    endproperty
    a_match: assert property (p_match)
        else $error("address match not flagged");

    property p_addr_ack;
        (state_q == i2cst_pkg::ST_ACK) && addr_phase_q |-> sda_oe_o;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge not driven");

    property p_rx_ack;
        step_ok && (state_q == i2cst_pkg::ST_DATA) && !tx_mode_q &&
        scl_fall && (bit_cnt_q == i2cst_pkg::BYTE_BITS)
        |=> sda_oe_o == !$past(ack_to_send_i);
    endproperty
    a_rx_ack: assert property (p_rx_ack)
        else $error("receive acknowledge value wrong");

    property p_hold;
        (state_q == i2cst_pkg::ST_HOLD) && !tx_data_wr_i && !data_rd_i
        && step_ok |=> scl_oe_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("clock line not held");

    property p_release;
        step_ok && (state_q == i2cst_pkg::ST_HOLD) && data_rd_i
        |=> !scl_oe_o && !byte_done_flag_o;
    endproperty
    a_release: assert property (p_release)
        else $error("clock line not released");

    property p_nack_free;
        (state_q == i2cst_pkg::ST_WAIT) |-> !sda_oe_o && !scl_oe_o;
    endproperty
    a_nack_free: assert property (p_nack_free)
        else $error("line driven while waiting for stop");

    property p_no_start;
        $rose(sda_oe_o) |-> !scl_f;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("data pulled low while clock high");

    property p_timeout;
        tmo_evt |=> timeout_flag_o && !timeout_enable_o && irq_o &&
                    byte_done_flag_o && ack_received_o &&
                    !address_match_flag_o && !bus_busy_flag_o;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("time-out effects missing");

    c_match: cover property (addr_hit ##[1:1000] data_rd_i);
    c_tx_byte: cover property ((state_q == i2cst_pkg::ST_MACK) && scl_fall);
    c_timeout: cover property (tmo_evt);
endmodule : i2cst_slave

// *** include/i2cst_pkg.sv ***
// constants and types shared by the two-wire slave engine
package i2cst_pkg;
    // interface mode code that selects the two-wire slave function
    localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
    // glitch filter select codes (1x selects the four-clock filter)
    localparam logic [1:0] FLT_NONE = 2'h0;
    localparam logic [1:0] FLT_TWO = 2'h1;
    // idle level of both bus lines
    localparam logic LINE_IDLE = 1'b1;
    // bit counter figures
    localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // status values after reset or time-out
    localparam logic BYTE_DONE_RST = 1'b1;
    localparam logic ACK_RX_RST = 1'b1;
    // one time-out step, in slow clock periods
    localparam int TO_STEP_CYC = 32;
    localparam logic [4:0] TO_PRE_LAST = 5'(TO_STEP_CYC - 1);
    // protocol engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_HOLD,
        ST_DATA,
        ST_MACK,
        ST_WAIT
    } i2cst_state_t;
endpackage : i2cst_pkg

// *** hdl/i2cst_tmo.sv ***
// time-out counter running on the slow clock
`timescale 1ns/1ps
module i2cst_tmo (
    input wire logic slow_clk_i,
    input wire logic sys_rst_i,
    input wire logic run_i,
    input wire logic clr_tgl_i,
    input wire logic [5:0] period_sel_i,
    output logic ovf_tgl_o
);
    // reset brought into the slow domain
    logic rst_s1_q;
    logic rst_q;
    // synchronisers for the level, the toggle and the period
    logic run_s1_q;
    logic run_s2_q;
    logic clr_s1_q;
    logic clr_s2_q;
    logic clr_s3_q;
    logic [5:0] sel_s1_q;
    logic [5:0] sel_s2_q;
    // prescaler, step counter and halt state
    logic [4:0] pre_q;
    logic [5:0] step_q;
    logic halt_q;
    logic clr_ev;

    // two-stage crossing of every input
    always_ff @(posedge slow_clk_i) begin
        rst_s1_q <= sys_rst_i;
        rst_q <= rst_s1_q;
        run_s1_q <= run_i;
        run_s2_q <= run_s1_q;
        clr_s1_q <= clr_tgl_i;
        clr_s2_q <= clr_s1_q;
        clr_s3_q <= clr_s2_q;
        sel_s1_q <= period_sel_i;
        sel_s2_q <= sel_s1_q;
    end

    // clock-line falling edge seen here as a toggle change
    assign clr_ev = clr_s2_q ^ clr_s3_q;

    // count steps of 32 slow clocks; overflow halts the count
    always_ff @(posedge slow_clk_i) begin
        if (rst_q) begin
            pre_q <= 5'h0;
            step_q <= 6'h0;
            halt_q <= 1'b0;
            ovf_tgl_o <= 1'b0;
        end else if (!run_s2_q || clr_ev) begin
            // restart on every falling edge
            pre_q <= 5'h0;
            step_q <= 6'h0;
            if (!run_s2_q) begin
                halt_q <= 1'b0;
            end
        end else if (!halt_q) begin
            pre_q <= pre_q + 5'h1;
            if (pre_q == i2cst_pkg::TO_PRE_LAST) begin
                // (sel+1) steps elapsed
                if (step_q == sel_s2_q) begin
                    halt_q <= 1'b1; // counter stops
                    ovf_tgl_o <= ~ovf_tgl_o;
                end else begin
                    step_q <= step_q + 6'h1;
                end
            end
        end
    end
endmodule : i2cst_tmo

// *** verif/i2cst_master.sv ***
// bus master model for the far side of the two-wire slave
`timescale 1ns/1ps
module i2cst_master (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    // both lines released at time zero
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // half bit, above the eight cycle minimum
    task automatic half();
        repeat (12) @(negedge clk_i);
    endtask : half
    // release clock, wait out any stretch by the slave
    task automatic rise();
        scl_oe_o = 1'b0;
        for (int n = 0; n < 400 && scl_i !== 1'b1; n++) @(negedge clk_i);
        half();
    endtask : rise
    // data falls while clock high; only this side starts
    task automatic start();
        sda_oe_o = 1'b0;
        rise();
        sda_oe_o = 1'b1;
        half();
        scl_oe_o = 1'b1;
    endtask : start
    // one bit: drive b, sample the line while clock high
    task automatic bit_x(input logic b, output logic r);
        half();
        sda_oe_o = !b;
        half();
        rise();
        r = sda_i;
        scl_oe_o = 1'b1;
    endtask : bit_x
    // eight bits msb first, then ninth bit
    task automatic byte_x(input logic [7:0] d, input logic a,
                          output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(a, ak);
    endtask : byte_x
    // data rises while clock high
    task automatic stop();
        half();
        sda_oe_o = 1'b1;
        half();
        rise();
        sda_oe_o = 1'b0;
        half();
    endtask : stop
endmodule : i2cst_master

// *** verif/i2cst_slave_tb_top.sv ***
// self-checking bench for the two-wire slave engine
`timescale 1ns/1ps
module i2cst_slave_tb_top;
    logic sys_clk_i = 1'b0, slow_clk_i = 1'b0, sys_rst_i, scl_i, sda_i;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl_oe, m_sda_oe;
    logic module_enable_i, transmit_select_i, ack_to_send_i, tx_data_wr_i;
    logic data_rd_i, timeout_ctrl_wr_i, timeout_enable_i, timeout_flag_clr_i;
    logic [2:0] interface_mode_sel_i;
    logic [1:0] glitch_filter_sel_i;
    logic [6:0] own_address_i;
    logic [7:0] tx_data_i, shift_data_o;
    logic [5:0] timeout_period_sel_i;
    logic byte_done_flag_o, address_match_flag_o, bus_busy_flag_o, irq_o;
    logic master_read_flag_o, ack_received_o, timeout_enable_o;
    logic timeout_flag_o;
    int fails = 0, n_checks = 0, irqs = 0;
    // clocks of the two unrelated domains
    always #20 sys_clk_i = ~sys_clk_i;
    always #7.5 slow_clk_i = ~slow_clk_i;
    // open drain wires with pull-ups
    assign scl_i = !(m_scl_oe | scl_oe_o);
    assign sda_i = !(m_sda_oe | sda_oe_o);
    // count interrupt pulses
    always @(negedge sys_clk_i) if (irq_o === 1'b1) irqs <= irqs + 1;
    i2cst_slave uut (.sys_clk_i, .sys_rst_i, .slow_clk_i, .scl_i, .scl_o,
        .scl_oe_o, .sda_i, .sda_o, .sda_oe_o, .module_enable_i,
        .interface_mode_sel_i, .glitch_filter_sel_i, .own_address_i,
        .transmit_select_i, .ack_to_send_i, .tx_data_i, .tx_data_wr_i,
        .data_rd_i, .timeout_ctrl_wr_i, .timeout_enable_i,
        .timeout_period_sel_i, .timeout_flag_clr_i, .shift_data_o,
        .byte_done_flag_o, .address_match_flag_o, .bus_busy_flag_o,
        .master_read_flag_o, .ack_received_o, .timeout_enable_o,
        .timeout_flag_o, .irq_o);
    i2cst_master m (.clk_i(sys_clk_i), .scl_i(scl_i), .sda_i(sda_i),
        .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // verdict and end of run
    task automatic results();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // one cycle software strobe
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk_i);
        s = 1'b0;
    endtask : pulse
    // clock held after ninth bit until the strobe
    task automatic hold_rel(ref logic s);
        repeat (12) @(negedge sys_clk_i);
        chk(scl_oe_o, 1'b1);
        pulse(s);
        @(negedge sys_clk_i);
        chk(scl_oe_o, 1'b0);
    endtask : hold_rel
    // start and address byte
    task automatic addr(input logic [6:0] a, input logic rw, output logic ak);
        logic [7:0] r;
        m.start();
        chk(bus_busy_flag_o, 1'b1);
        m.byte_x({a, rw}, 1'b1, r, ak);
    endtask : addr
    // hang guard
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        fails++;
        results();
    end
    // main sequence
    initial begin
        logic [7:0] d, r;
        logic ak;
        int base;
        void'($urandom(32'hb3f4_b599));
        {tx_data_wr_i, data_rd_i, timeout_ctrl_wr_i, timeout_enable_i} = '0;
        {timeout_flag_clr_i, transmit_select_i, ack_to_send_i} = '0;
        {tx_data_i, timeout_period_sel_i, own_address_i} = '0;
        sys_rst_i = 1'b1;
        module_enable_i = 1'b1;
        interface_mode_sel_i = i2cst_pkg::MODE_I2C_SLAVE;
        glitch_filter_sel_i = i2cst_pkg::FLT_NONE;
        repeat (10) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        chk(byte_done_flag_o, 1'b1);
        chk(bus_busy_flag_o, 1'b0);
        for (int i = 0; i < 3; i++) begin
            glitch_filter_sel_i = 2'(i);
            own_address_i = 7'($urandom);
            ack_to_send_i = 1'($urandom);
            d = 8'($urandom);
            base = irqs;
            addr(own_address_i, 1'b0, ak);
            chk(ak, 1'b0);
            chk(address_match_flag_o, 1'b1);
            chk(master_read_flag_o, 1'b0);
            hold_rel(data_rd_i);
            chk(byte_done_flag_o, 1'b0);
            m.byte_x(d, 1'b1, r, ak);
            chk(ak, ack_to_send_i);
            chk(shift_data_o, d);
            chk(byte_done_flag_o, 1'b1);
            hold_rel(data_rd_i);
            m.stop();
            chk(bus_busy_flag_o, 1'b0);
            chk(8'(irqs - base), 8'h02);
            transmit_select_i = 1'b1;
            tx_data_i = d;
            addr(own_address_i, 1'b1, ak);
            chk(master_read_flag_o, 1'b1);
            hold_rel(tx_data_wr_i);
            m.byte_x(8'hff, 1'b1, r, ak);
            chk(r, d);
            chk(ack_received_o, 1'b1);
            chk(sda_oe_o, 1'b0);
            m.stop();
            transmit_select_i = 1'b0;
            addr(own_address_i ^ 7'h40, 1'b0, ak);
            chk(ak, 1'b1);
            chk(address_match_flag_o, 1'b0);
            m.stop();
        end
        // long period: falls restart the count, stop halts it
        timeout_period_sel_i = 6'h07;
        timeout_enable_i = 1'b1;
        pulse(timeout_ctrl_wr_i);
        addr(own_address_i, 1'b0, ak);
        hold_rel(data_rd_i);
        m.byte_x(d, 1'b1, r, ak);
        hold_rel(data_rd_i);
        m.stop();
        repeat (200) @(negedge sys_clk_i);
        chk(timeout_flag_o, 1'b0);
        // other mode selected mid-frame: engine back to idle
        addr(own_address_i, 1'b0, ak);
        repeat (12) @(negedge sys_clk_i);
        chk(scl_oe_o, 1'b1);
        interface_mode_sel_i = 3'h5;
        repeat (2) @(negedge sys_clk_i);
        chk(address_match_flag_o, 1'b0);
        chk(scl_oe_o, 1'b0);
        interface_mode_sel_i = i2cst_pkg::MODE_I2C_SLAVE;
        m.stop();
        chk(timeout_flag_o, 1'b0);
        timeout_period_sel_i = 6'h00;
        chk(timeout_enable_o, 1'b1);
        base = irqs;
        addr(own_address_i, 1'b0, ak);
        for (int n = 0; n < 300 && timeout_flag_o !== 1'b1; n++)
            @(negedge sys_clk_i);
        chk(timeout_flag_o, 1'b1);
        chk(timeout_enable_o, 1'b0);
        chk(address_match_flag_o, 1'b0);
        chk(scl_oe_o, 1'b0);
        chk(shift_data_o, {own_address_i, 1'b0});
        chk(8'(irqs - base), 8'h02);
        pulse(timeout_flag_clr_i);
        chk(timeout_flag_o, 1'b0);
        m.stop();
        results();
    end
endmodule : i2cst_slave_tb_top
